// ==== verilog/spmp_mode_ctrl.sv ====
// Operation
// RULE_01: enable low always leads to shutdown, whatever the pixel clock does.
// RULE_02: shutdown stops capture, pll, serializer, output stage; all outputs high-z.
// RULE_03: enable high and pixel clock under 500 kHz gives standby.
// RULE_04: standby runs only the activity monitor; pll off, outputs high-z.
// RULE_05: enable high and pixel clock over 3 MHz starts the active sequence.
// RULE_06: acquire runs the pll with outputs high-z; lock moves to transmit.
// RULE_07: transmit drives the clock copy and the selected lanes; lane one obeys mode.
// RULE_08: parity covers 24 pixel bits plus both syncs and data valid only.
// RULE_09: parity bit set when covered bits hold an even count of ones.
// RULE_10: enable high for over 10 us leaves shutdown into standby.
// RULE_11: activity seen in standby enables the pll and enters acquire.
// RULE_12: lock within 2 ms latches the frame and turns outputs on.
// RULE_13: missing pixel clock in transmit goes to standby, pll off, monitor on.
// RULE_14: enable low over 10 us shuts down; clock output released first.
// RULE_15: input stages keep sampling in shutdown so enable is still seen.
// RULE_16: host keeps the pixel clock inside the valid range for the lane mode.
// RULE_17: lane select low is single lane, high drives both lanes.
// RULE_18: between the two thresholds the current mode is kept.
// RULE_19: activity is measured against the free-running clock, not the pll.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
module spmp_mode_ctrl #(
  parameter int LOCK_CYC = spmp_pkg::LOCK_WAIT_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic transmit_enable_in,
  input wire logic pixel_clock_in,
  input wire logic [spmp_pkg::PIXEL_W-1:0] pixel_data_in,
  input wire logic vertical_sync_in,
  input wire logic horizontal_sync_in,
  input wire logic video_data_valid_in,
  input wire logic lane_select_in,
  input wire logic pll_lock_in,
  input wire logic [spmp_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic pll_enable_out,
  output logic monitor_enable_out,
  output logic capture_enable_out,
  output logic serializer_enable_out,
  output logic clock_out,
  output logic clock_oe_out,
  output logic serial_lane_zero_out,
  output logic serial_lane_zero_oe_out,
  output logic serial_lane_one_out,
  output logic serial_lane_one_oe_out,
  output logic [spmp_pkg::FRAME_W-1:0] frame_word_out
);
  import spmp_pkg::*;

  localparam int HOLD_W = $clog2(ENABLE_HOLD_CYC + 1);
  localparam int LOCK_W = $clog2(LOCK_CYC + 1);

  typedef struct packed {
    spmp_mode_t mode;
    logic en_s1;
    logic en_s2;
    logic pclk_s1;
    logic pclk_s2;
    logic pclk_s3;
    logic lock_s1;
    logic lock_s2;
    logic lane_s1;
    logic lane_s2;
    logic [PAYLOAD_W-1:0] pay_s1;
    logic [PAYLOAD_W-1:0] pay_s2;
    logic [HOLD_W-1:0] hold_cnt;
    logic [LOCK_W-1:0] lock_cnt;
    logic ctrl_edge;
    logic wait_r;
    logic [31:0] rdata;
    logic [FRAME_W-1:0] frame;
    logic pll_en;
    logic mon_en;
    logic cap_en;
    logic ser_en;
    logic clk_o;
    logic clk_oe;
    logic l0_oe;
    logic l1_oe;
    logic l0_o;
    logic l1_o;
  } spmp_state_t;

  spmp_state_t r;
  spmp_state_t r_nxt;
  logic mon_active;
  logic parity_bit;
  logic cap_edge;
  logic [FRAME_W-1:0] frame_new;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // modes in which the pll runs
  function automatic logic pll_mode(input spmp_mode_t m);
    return (m == MODE_ACQUIRE) || (m == MODE_TRANSMIT);
  endfunction

  // modes in which the monitor runs; parking keeps it so a quick return works
  function automatic logic mon_mode(input spmp_mode_t m);
    return pll_mode(m) || (m == MODE_STANDBY) || (m == MODE_QUIESCE)
      || (m == MODE_PARKING);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // sub blocks

  spmp_clock_monitor #(
    .WINDOW_CYC(MON_WINDOW_CYC),
    .SLOW_CNT(SLOW_EDGES),
    .FAST_CNT(FAST_EDGES)
  ) u_monitor (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .enable_in(r.mon_en),
    .edge_in(r.pclk_s2 & ~r.pclk_s3),
    .active_out(mon_active)
  );

  spmp_parity #(
    .PAYLOAD_BITS(PAYLOAD_W)
  ) u_parity (
    .payload_in(r.pay_s2),
    .parity_out(parity_bit)
  );

  // reserved bits go out as zero and stay outside the parity
  assign frame_new = {2'h0, parity_bit, r.pay_s2}; // see RULE_08
  // capture edge follows the polarity chosen in the control register
  assign cap_edge = r.ctrl_edge ? (~r.pclk_s2 & r.pclk_s3) : (r.pclk_s2 & ~r.pclk_s3);

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_nxt = r;
    // input stages sample in every mode, shutdown included
    r_nxt.en_s1 = transmit_enable_in; // see RULE_15
    r_nxt.en_s2 = r.en_s1;
    r_nxt.pclk_s1 = pixel_clock_in;
    r_nxt.pclk_s2 = r.pclk_s1;
    r_nxt.pclk_s3 = r.pclk_s2;
    r_nxt.lock_s1 = pll_lock_in;
    r_nxt.lock_s2 = r.lock_s1;
    r_nxt.lane_s1 = lane_select_in;
    r_nxt.lane_s2 = r.lane_s1;
    r_nxt.pay_s1 = {video_data_valid_in, horizontal_sync_in, vertical_sync_in, pixel_data_in};
    r_nxt.pay_s2 = r.pay_s1;

    // mode sequencing
    unique case (r.mode)
      MODE_SHUTDOWN: begin
        if (!r.en_s2) begin
          r_nxt.hold_cnt = '0;
        end else if (r.hold_cnt == HOLD_W'(ENABLE_HOLD_CYC)) begin
          r_nxt.mode = MODE_STANDBY; // see RULE_10
          r_nxt.hold_cnt = '0;
        end else begin
          r_nxt.hold_cnt = r.hold_cnt + HOLD_W'(1);
        end
      end
      MODE_STANDBY: begin
        if (!r.en_s2) begin
          r_nxt.mode = MODE_PARKING; // see RULE_01
        end else if (mon_active) begin
          r_nxt.mode = MODE_ACQUIRE; // see RULE_11
          r_nxt.lock_cnt = '0;
        end
      end
      MODE_ACQUIRE: begin
        if (!r.en_s2) begin
          r_nxt.mode = MODE_PARKING;
        end else if (!mon_active) begin
          r_nxt.mode = MODE_STANDBY;
        end else if (r.lock_s2) begin
          r_nxt.mode = MODE_TRANSMIT; // see RULE_06
          r_nxt.frame = frame_new; // see RULE_12
        end else if (r.lock_cnt == LOCK_W'(LOCK_CYC - 1)) begin
          // no lock in time: drop the pll and let the monitor retry
          r_nxt.mode = MODE_STANDBY; // see RULE_12
        end else begin
          r_nxt.lock_cnt = r.lock_cnt + LOCK_W'(1);
        end
      end
      MODE_TRANSMIT: begin
        if (!r.en_s2) begin
          r_nxt.mode = MODE_QUIESCE; // see RULE_14
        end else if (!mon_active) begin
          r_nxt.mode = MODE_STANDBY; // see RULE_13
        end else if (!r.lock_s2) begin
          r_nxt.mode = MODE_ACQUIRE;
          r_nxt.lock_cnt = '0;
        end else if (cap_edge) begin
          r_nxt.frame = frame_new;
        end
      end
      MODE_QUIESCE: begin
        r_nxt.mode = MODE_PARKING; // see RULE_14
        r_nxt.hold_cnt = '0;
      end
      MODE_PARKING: begin
        if (r.en_s2) begin
          r_nxt.mode = MODE_STANDBY;
          r_nxt.hold_cnt = '0;
        end else if (r.hold_cnt == HOLD_W'(ENABLE_HOLD_CYC)) begin
          r_nxt.mode = MODE_SHUTDOWN; // see RULE_14
          r_nxt.hold_cnt = '0;
        end else begin
          r_nxt.hold_cnt = r.hold_cnt + HOLD_W'(1);
        end
      end
      default: begin
        r_nxt.mode = MODE_SHUTDOWN;
      end
    endcase

    // enables and drive follow the next mode, so every output is a flop
    r_nxt.pll_en = pll_mode(r_nxt.mode); // see RULE_04
    r_nxt.mon_en = mon_mode(r_nxt.mode); // see RULE_02
    r_nxt.cap_en = (r_nxt.mode == MODE_TRANSMIT);
    r_nxt.ser_en = (r_nxt.mode == MODE_TRANSMIT);
    r_nxt.clk_oe = (r_nxt.mode == MODE_TRANSMIT); // see RULE_07
    r_nxt.clk_o = r_nxt.clk_oe & r.pclk_s2;
    // lanes stay on one cycle longer than the clock when shutting down
    r_nxt.l0_oe = (r_nxt.mode == MODE_TRANSMIT) || (r_nxt.mode == MODE_QUIESCE);
    r_nxt.l1_oe = r_nxt.l0_oe & r.lane_s2; // see RULE_17
    // lane data registered here so the pins come straight from a flop
    r_nxt.l0_o = r_nxt.l0_oe & r_nxt.frame[0];
    r_nxt.l1_o = r_nxt.l1_oe & r_nxt.frame[LANE1_FIRST_BIT];

    // register slave: answer on the second edge of each request
    r_nxt.wait_r = 1'h1;
    if ((avs_read_in || avs_write_in) && r.wait_r) begin
      r_nxt.wait_r = 1'h0;
      r_nxt.rdata = '0;
      if (avs_read_in && avs_address_in == REG_STATUS) begin
        r_nxt.rdata[ST_MODE_LSB +: 3] = r.mode;
        r_nxt.rdata[ST_LOCK_BIT] = r.lock_s2;
        r_nxt.rdata[ST_ACTIVE_BIT] = mon_active;
        r_nxt.rdata[ST_LANE_BIT] = r.lane_s2;
        r_nxt.rdata[ST_PARITY_BIT] = r.frame[FRAME_PARITY_BIT];
      end else if (avs_read_in && avs_address_in == REG_CTRL) begin
        r_nxt.rdata[CTRL_EDGE_BIT] = r.ctrl_edge;
      end
    end
    // a write lands at the edge at which the master sees waitrequest low
    if (avs_write_in && !r.wait_r && avs_address_in == REG_CTRL
        && avs_byteenable_in[0]) begin
      r_nxt.ctrl_edge = avs_writedata_in[CTRL_EDGE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
      r.mode <= MODE_SHUTDOWN;
      r.ctrl_edge <= CTRL_EDGE_RESET;
      r.wait_r <= 1'h1;
    end else begin
      r <= r_nxt;
    end
  end

  // lane bits show the first bit of each lane's part of the latched frame
  assign avs_readdata_out = r.rdata;
  assign avs_waitrequest_out = r.wait_r;
  assign pll_enable_out = r.pll_en;
  assign monitor_enable_out = r.mon_en;
  assign capture_enable_out = r.cap_en;
  assign serializer_enable_out = r.ser_en;
  assign clock_out = r.clk_o;
  assign clock_oe_out = r.clk_oe;
  assign serial_lane_zero_out = r.l0_o;
  assign serial_lane_zero_oe_out = r.l0_oe;
  assign serial_lane_one_out = r.l1_o;
  assign serial_lane_one_oe_out = r.l1_oe;
  assign frame_word_out = r.frame;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_shutdown_all_off: assert property ( // see RULE_02
    r.mode == MODE_SHUTDOWN |-> !r.clk_oe && !r.l0_oe && !r.l1_oe && !r.pll_en && !r.mon_en)
    else $error("outputs or circuits alive in shutdown");
  a_standby_pll_off: assert property ( // see RULE_04
    r.mode == MODE_STANDBY |-> !r.pll_en && r.mon_en && !r.l0_oe && !r.clk_oe)
    else $error("standby drives outputs or runs pll");
  a_acquire_hiz: assert property ( // see RULE_06
    r.mode == MODE_ACQUIRE |-> r.pll_en && !r.clk_oe && !r.l0_oe && !r.l1_oe)
    else $error("acquire state wrong");
  a_clock_copy: assert property ( // see RULE_07
    r.clk_oe |-> r.clk_o == $past(r.pclk_s2))
    else $error("forwarded clock is not the pixel clock");
  a_lane_one_mode: assert property ( // see RULE_17
    r.l1_oe |-> $past(r.lane_s2) && r.l0_oe)
    else $error("lane one driven in single lane mode");
  a_frame_odd: assert property ( // see RULE_09
    r.mode == MODE_TRANSMIT |-> (^r.frame[FRAME_PARITY_BIT:0]) == 1'h1)
    else $error("frame parity is not odd");
  a_reserved_zero: assert property ( // see RULE_08
    r.frame[FRAME_W-1:FRAME_RSVD_LSB] == 2'h0)
    else $error("reserved frame bits set");
  a_enable_low_quiet: assert property ( // see RULE_01
    !r.en_s2 |=> !r.clk_oe ##1 !r.l0_oe)
    else $error("outputs driven with enable low");
  a_clock_first: assert property ( // see RULE_14
    r.mode == MODE_TRANSMIT && !r.en_s2 |=> !r.clk_oe && r.l0_oe ##1 !r.l0_oe)
    else $error("clock not released before lanes");
  a_leave_shutdown: assert property ( // see RULE_10
    r.mode == MODE_STANDBY && $past(r.mode) == MODE_SHUTDOWN
    |-> $past(r.hold_cnt) == HOLD_W'(ENABLE_HOLD_CYC))
    else $error("shutdown left before enable held long enough");
  a_standby_to_acq: assert property ( // see RULE_11
    r.mode == MODE_STANDBY && r.en_s2 && mon_active |=> r.mode == MODE_ACQUIRE && r.pll_en)
    else $error("activity did not start acquire");
  a_lock_bound: assert property ( // see RULE_12
    r.mode == MODE_ACQUIRE |-> r.lock_cnt < LOCK_W'(LOCK_CYC))
    else $error("lock wait overran");
  a_lost_clock: assert property ( // see RULE_13
    r.mode == MODE_TRANSMIT && r.en_s2 && !mon_active
    |=> r.mode == MODE_STANDBY && !r.pll_en && r.mon_en && !r.l0_oe)
    else $error("missing clock not handled");
endmodule

// ==== verilog/spmp_pkg.sv ====
package spmp_pkg;

  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int ENABLE_HOLD_NS = 10_000;
  // a least time, so rounded up
  localparam int ENABLE_HOLD_CYC = (ENABLE_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_WAIT_US = 2000;
  // a longest time, so rounded down
  localparam int LOCK_WAIT_CYC = LOCK_WAIT_US * CLK_MHZ;

  // pixel clock activity monitor
  localparam int MON_WINDOW_NS = 16_000;
  localparam int MON_WINDOW_CYC = (MON_WINDOW_NS * CLK_MHZ) / 1000;
  localparam int STANDBY_KHZ = 500;
  localparam int ACTIVE_KHZ = 3000;
  localparam int SLOW_EDGES = (STANDBY_KHZ * MON_WINDOW_NS) / 1_000_000;
  localparam int FAST_EDGES = (ACTIVE_KHZ * MON_WINDOW_NS) / 1_000_000;

  // frame layout
  localparam int PIXEL_W = 24;
  localparam int PAYLOAD_W = 27;
  localparam int FRAME_W = 30;
  localparam int FRAME_PARITY_BIT = 27;
  localparam int FRAME_RSVD_LSB = 28;
  localparam int LANE1_FIRST_BIT = 15;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam int CTRL_EDGE_BIT = 0;
  localparam logic CTRL_EDGE_RESET = 1'h0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_LOCK_BIT = 4;
  localparam int ST_ACTIVE_BIT = 5;
  localparam int ST_LANE_BIT = 6;
  localparam int ST_PARITY_BIT = 7;

  typedef enum logic [2:0] {
    MODE_SHUTDOWN = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_ACQUIRE = 3'h2,
    MODE_TRANSMIT = 3'h3,
    MODE_QUIESCE = 3'h4,
    MODE_PARKING = 3'h5
  } spmp_mode_t;

endpackage

// ==== verilog/spmp_parity.sv ====
`timescale 1ns/1ns
module spmp_parity #(
  parameter int PAYLOAD_BITS = spmp_pkg::PAYLOAD_W
) (
  input wire logic [PAYLOAD_BITS-1:0] payload_in,
  output logic parity_out
);
  import spmp_pkg::*;

  // set on an even count of ones so the word with parity is odd
  assign parity_out = ~(^payload_in); // see RULE_09
endmodule

// ==== verilog/spmp_clock_monitor.sv ====
`timescale 1ns/1ns
module spmp_clock_monitor #(
  parameter int WINDOW_CYC = spmp_pkg::MON_WINDOW_CYC,
  parameter int SLOW_CNT = spmp_pkg::SLOW_EDGES,
  parameter int FAST_CNT = spmp_pkg::FAST_EDGES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic enable_in,
  input wire logic edge_in,
  output logic active_out
);
  import spmp_pkg::*;

  localparam int WIN_W = $clog2(WINDOW_CYC);
  localparam int EDGE_W = $clog2(WINDOW_CYC / 2 + 2);

  typedef struct packed {
    logic [WIN_W-1:0] win;
    logic [EDGE_W-1:0] edges;
    logic active;
  } spmp_mon_t;

  spmp_mon_t r;
  spmp_mon_t r_nxt;

  // count edges over a fixed window of the free-running clock; between the
  // two thresholds the verdict is kept, so a clock near one does not chatter
  always_comb begin
    r_nxt = r;
    if (!enable_in) begin
      r_nxt = '0;
    end else if (r.win == WIN_W'(WINDOW_CYC - 1)) begin // see RULE_19
      r_nxt.win = '0;
      r_nxt.edges = '0;
      if (r.edges > EDGE_W'(FAST_CNT)) begin
        r_nxt.active = 1'h1; // see RULE_05
      end else if (r.edges < EDGE_W'(SLOW_CNT)) begin
        r_nxt.active = 1'h0; // see RULE_03
      end // see RULE_18
    end else begin
      r_nxt.win = r.win + WIN_W'(1);
      if (edge_in) begin
        r_nxt.edges = r.edges + EDGE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign active_out = r.active;

  a_hold_between: assert property (@(posedge clk_in) disable iff (!rstn_in) // see RULE_18
    enable_in && r.win == WIN_W'(WINDOW_CYC - 1) && r.edges >= EDGE_W'(SLOW_CNT)
    && r.edges <= EDGE_W'(FAST_CNT) |=> r.active == $past(r.active))
    else $error("monitor verdict changed between thresholds");
  a_fast_detect: assert property (@(posedge clk_in) disable iff (!rstn_in) // see RULE_05
    enable_in && r.win == WIN_W'(WINDOW_CYC - 1) && r.edges > EDGE_W'(FAST_CNT)
    |=> r.active)
    else $error("fast pixel clock not reported active");
endmodule

// ==== test/spmp_host_model.sv ====
`timescale 1ns/1ns
module spmp_host_model #(
  parameter int LOCK_DLY = 40
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic pll_enable_in,
  output logic pixel_clock_out,
  output logic pll_lock_out
);
  int lock_cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // host pixel clock, 320 ns, phase unrelated to clk_in; parks low when stopped
  initial begin
    pixel_clock_out = 1'b0;
    #7;
    forever begin
      #160;
      if (run_in) begin
        pixel_clock_out = ~pixel_clock_out;
      end else begin
        pixel_clock_out = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll stand-in: lock comes a fixed while after enable, drops with enable
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in || !pll_enable_in) begin
      lock_cnt_r <= 0;
      pll_lock_out <= 1'b0;
    end else if (lock_cnt_r == LOCK_DLY) begin
      pll_lock_out <= 1'b1;
    end else begin
      lock_cnt_r <= lock_cnt_r + 1;
    end
  end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) check_eq(32'(got), 32'(exp))
module tb;
  import spmp_pkg::*;
  localparam int LOCK_CYC = 200;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic transmit_enable = 1'b0;
  logic run = 1'b0;
  logic [26:0] payload = 27'h0;
  logic lane_select = 1'b0;
  logic [ADDR_W-1:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest, pll_en, mon_en, cap_en, ser_en, clk_o, clk_oe;
  logic l0, l0_oe, l1, l1_oe, pix_clk, lock;
  logic [FRAME_W-1:0] frame;
  logic [31:0] s;
  logic [29:0] ef;
  int err_count = 0;
  int comparisons = 0;

  spmp_mode_ctrl #(.LOCK_CYC(LOCK_CYC)) DUT (
    .clk_in(clk_in), .rstn_in(rstn_in), .transmit_enable_in(transmit_enable),
    .pixel_clock_in(pix_clk), .pixel_data_in(payload[23:0]), .vertical_sync_in(payload[24]),
    .horizontal_sync_in(payload[25]), .video_data_valid_in(payload[26]),
    .lane_select_in(lane_select), .pll_lock_in(lock), .avs_address_in(address),
    .avs_read_in(read), .avs_write_in(write), .avs_writedata_in(writedata),
    .avs_byteenable_in(byteenable), .avs_readdata_out(readdata),
    .avs_waitrequest_out(waitrequest), .pll_enable_out(pll_en), .monitor_enable_out(mon_en),
    .capture_enable_out(cap_en), .serializer_enable_out(ser_en), .clock_out(clk_o),
    .clock_oe_out(clk_oe), .serial_lane_zero_out(l0), .serial_lane_zero_oe_out(l0_oe),
    .serial_lane_one_out(l1), .serial_lane_one_oe_out(l1_oe), .frame_word_out(frame));

  spmp_host_model host (.clk_in(clk_in), .rstn_in(rstn_in), .run_in(run),
    .pll_enable_in(pll_en), .pixel_clock_out(pix_clk), .pll_lock_out(lock));

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the run needs some 4200 cycles, so 20000 is ample
  initial begin
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("FAIL at %0t ns: watchdog expired", $time);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one avalon access; the request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge clk_in);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= wd;
    byteenable <= be;
    do begin
      @(posedge clk_in);
    end while (waitrequest !== 1'b0);
    `CHK(waitrequest, 0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // polls the status mode field; a mode change is slow, so polling costs nothing
  task automatic wait_mode(input spmp_mode_t m);
    int n = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0, 4'hf, s);
      n++;
    end while (s[2:0] !== m && n < 1000);
    `CHK(s[2:0], m);
  endtask

  function automatic logic [29:0] exp_frame(input logic [26:0] p);
    return {2'h0, ~^p, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int cnt;
    logic prev;
    void'($urandom(18157));
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    `CHK({pll_en, mon_en, clk_oe, l0_oe, l1_oe, waitrequest}, 6'h01);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    `CHK(s, 32'h0);
    bus(1'b0, REG_CTRL, 32'h0, 4'hf, s);
    `CHK(s, 32'h0);
    bus(1'b1, REG_CTRL, 32'hffff_ffff, 4'hf, s);
    bus(1'b1, REG_CTRL, 32'h0, 4'he, s);
    bus(1'b0, REG_CTRL, 32'h0, 4'hf, s);
    `CHK(s, 32'h1);
    bus(1'b0, 4'h8, 32'h0, 4'hf, s);
    `CHK(s, 32'h0);
    bus(1'b1, REG_CTRL, 32'h0, 4'hf, s);
    $display("test registers done");
    // a pulse shorter than the hold time is refused
    transmit_enable <= 1'b1;
    repeat (100) @(posedge clk_in);
    transmit_enable <= 1'b0;
    repeat (300) @(posedge clk_in);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    `CHK({s[2:0], mon_en}, {MODE_SHUTDOWN, 1'b0});
    transmit_enable <= 1'b1;
    repeat (200) @(posedge clk_in);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    `CHK(s[2:0], MODE_SHUTDOWN);
    wait_mode(MODE_STANDBY);
    `CHK({pll_en, mon_en, clk_oe, l0_oe, l1_oe}, 5'h08);
    repeat (900) @(posedge clk_in);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    `CHK(s[2:0], MODE_STANDBY);
    $display("test standby done");
    // pixel clock starts: acquire with outputs off, then transmit on lock
    run <= 1'b1;
    wait_mode(MODE_ACQUIRE);
    `CHK({pll_en, clk_oe, l0_oe, l1_oe}, 4'h8);
    wait_mode(MODE_TRANSMIT);
    `CHK({cap_en, ser_en, clk_oe, l0_oe}, 4'hf);
    cnt = 0;
    prev = clk_o;
    repeat (80) begin
      @(posedge clk_in);
      if (clk_o === 1'b1 && prev === 1'b0) cnt++;
      prev = clk_o;
    end
    `CHK(cnt >= 9 && cnt <= 11, 1);
    // corner payloads first, then random ones, lane mode alternating
    for (int i = 0; i < 8; i++) begin
      // every other pair of payloads is captured on the falling pixel clock edge
      bus(1'b1, REG_CTRL, {31'h0, i[1]}, 4'hf, s);
      payload <= (i == 0) ? 27'h0 : (i == 1) ? 27'h7ff_ffff : 27'($urandom());
      lane_select <= i[0];
      repeat (40) @(posedge clk_in);
      ef = exp_frame(payload);
      `CHK(frame, ef);
      `CHK(frame[27], ~^payload);
      `CHK({l1_oe, l0_oe, l0}, {i[0], 1'b1, ef[0]});
      if (i[0]) `CHK(l1, ef[15]);
      else `CHK(l1, 1'b0);
      bus(1'b0, REG_STATUS, 32'h0, 4'hf, s);
      `CHK(s[7:4], {ef[27], i[0], 2'h3});
    end
    $display("test transmit done");
    // pixel clock stops: back to standby
    run <= 1'b0;
    wait_mode(MODE_STANDBY);
    `CHK({pll_en, mon_en, clk_oe, l0_oe, l1_oe}, 5'h08);
    run <= 1'b1;
    wait_mode(MODE_TRANSMIT);
    $display("test restart done");
    // enable low: clock output released one cycle before the lanes
    transmit_enable <= 1'b0;
    cnt = 0;
    do begin
      @(posedge clk_in);
      cnt++;
    end while (clk_oe !== 1'b0 && cnt < 10);
    `CHK({clk_oe, l0_oe}, 2'h1);
    @(posedge clk_in);
    `CHK(l0_oe, 0);
    repeat (100) @(posedge clk_in);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    `CHK(s[2:0], MODE_PARKING);
    wait_mode(MODE_SHUTDOWN);
    `CHK({pll_en, mon_en, cap_en, ser_en, clk_oe, l0_oe, l1_oe}, 7'h0);
    $display("test shutdown done");
    end_of_test();
  end
endmodule
